// >>> rtl/scan_meter_consts.vh
// offsets, fields, reset values and timing counts for the scanning meter handshake
// Functional notes
// RULE_01: multiplexers sit at consecutive following logical addresses
// RULE_02: meter raises interrupts and accepts acknowledge
// RULE_03: one of seven lines, strap chosen, line 1
// RULE_04: strap off setting raises no interrupt
// RULE_05: acknowledge daisy chain, nearest slot wins
// RULE_06: integrate over whole number of line cycles
// RULE_07: line frequency accepts only 50 or 60
// RULE_08: minimum selects 50, maximum selects 60
// RULE_09: frequency non-volatile, ships 60, set-only change
// RULE_10: query returns current, minimum and maximum
// RULE_11: bus is complete, trigger and ground
// RULE_12: trigger from multiplexer starts one measurement
// RULE_13: assert complete when each measurement finishes
// RULE_14: multiplexer advances channel on each complete
// RULE_15: handshake runs alone, about 13150 channels/s
// RULE_16: handshake only with all solid-state multiplexers
// RULE_17: commands queued during trigger wait, clear discards
// RULE_18: synced trigger edge, fixed-width complete pulse
`ifndef SCAN_METER_CONSTS_VH
`define SCAN_METER_CONSTS_VH
`define CLK_HZ 50000000
`define CLK_PERIOD_NS 20
`define ADDR_CTRL 8'h00
`define ADDR_LFREQ 8'h04
`define ADDR_NPLC 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_CMD 8'h10
`define ADDR_COUNT 8'h14
`define CTRL_RUN 0
`define CTRL_SOLID 1
`define CTRL_CLEAR 2
`define CTRL_IRQ_EN 3
`define LFREQ_MIN_BIT 8
`define LFREQ_MAX_BIT 9
`define LFREQ_MIN 8'd50
`define LFREQ_MAX 8'd60
`define LFREQ_FACTORY 8'd60
`define NPLC_RESET 8'h01
`define STAT_ERR_BIT 3
`define COMPLETE_NS 1000
`define COMPLETE_CYCLES 8'd50
`define LC50_CYCLES 20'd1000000
`define LC60_CYCLES 20'd833333
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESP_DECERR 2'b11
`endif

// >>> rtl/scanning_meter_handshake.v
// scanning meter: trigger/complete handshake, backplane interrupt, line-frequency setting
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`include "scan_meter_consts.vh"
module scanning_meter_handshake #(
  parameter [19:0] LC50_CYCLES = `LC50_CYCLES,
  parameter [19:0] LC60_CYCLES = `LC60_CYCLES,
  parameter [7:0] COMPLETE_CYCLES = `COMPLETE_CYCLES
) (
  // clock and resets
  input wire SYS_CLK,
  input wire RESET_N,
  input wire POR_N,
  // axi4-lite write
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // axi4-lite read
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // digital bus
  input wire TRIG_IN, // [RULE_11]
  output reg MEAS_COMPLETE,
  // backplane interrupt
  input wire [2:0] IRQ_SEL,
  output reg [6:0] IRQ_O,
  output reg [6:0] IRQ_OE,
  input wire IACKIN_N,
  output reg IACKOUT_N
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_MEAS = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  reg [1:0] state_q;
  reg [3:0] ctrl_q;
  reg [7:0] lfreq_q;
  reg [7:0] nplc_q;
  reg err_q;
  reg [7:0] pend_q;
  reg [15:0] exec_q;
  reg [15:0] count_q;
  reg [19:0] cyc_q;
  reg [7:0] lc_q;
  reg [7:0] pulse_q;
  reg irq_pend_q;
  reg [2:0] irq_sel_q;
  reg [2:0] irq_sel_s1_q;
  reg ack_hold_q;
  reg trig_s1_q, trig_s2_q, trig_s3_q;
  reg iack_s1_q, iack_s2_q;
  reg [7:0] aw_addr_q;
  reg aw_v_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_v_q;
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;

  wire trig_edge = trig_s2_q & ~trig_s3_q;
  wire hs_enable = ctrl_q[`CTRL_RUN] & ctrl_q[`CTRL_SOLID];
  wire do_write = aw_v_q & w_v_q & ~S_AXI_BVALID;
  wire wr_ctrl = do_write & ({aw_addr_q[7:2], 2'b00} == `ADDR_CTRL);
  wire wr_lfreq = do_write & ({aw_addr_q[7:2], 2'b00} == `ADDR_LFREQ);
  wire wr_nplc = do_write & ({aw_addr_q[7:2], 2'b00} == `ADDR_NPLC);
  wire wr_stat = do_write & ({aw_addr_q[7:2], 2'b00} == `ADDR_STATUS);
  wire wr_cmd = do_write & ({aw_addr_q[7:2], 2'b00} == `ADDR_CMD);
  wire wr_map = wr_ctrl | wr_lfreq | wr_nplc | wr_stat | wr_cmd;
  wire host_clear = wr_ctrl & w_strb_q[0] & w_data_q[`CTRL_CLEAR];
  wire [19:0] lc_len = (lfreq_q == `LFREQ_MIN) ? LC50_CYCLES : LC60_CYCLES;
  wire meas_start = (state_q == ST_WAIT) & trig_edge & hs_enable;
  wire meas_end = (state_q == ST_MEAS) & (cyc_q == lc_len - 20'd1) & (lc_q == 8'd1);

  // line-frequency request decode: min, max, or a literal 50/60
  reg lf_ok;
  reg [7:0] lf_new;
  always @* begin
    lf_ok = 1'b1;
    lf_new = lfreq_q;
    if (w_data_q[`LFREQ_MIN_BIT]) begin
      lf_new = `LFREQ_MIN; // [RULE_08]
    end else if (w_data_q[`LFREQ_MAX_BIT]) begin
      lf_new = `LFREQ_MAX; // [RULE_08]
    end else if (w_data_q[7:0] == `LFREQ_MIN || w_data_q[7:0] == `LFREQ_MAX) begin
      lf_new = w_data_q[7:0];
    end else begin
      lf_ok = 1'b0; // [RULE_07]
    end
  end

  // pin synchronisers
  always @(posedge SYS_CLK) begin
    trig_s1_q <= TRIG_IN;
    trig_s2_q <= trig_s1_q;
    trig_s3_q <= trig_s2_q; // [RULE_18]
    iack_s1_q <= IACKIN_N;
    iack_s2_q <= iack_s1_q;
    irq_sel_s1_q <= IRQ_SEL;
  end

  // non-volatile frequency: power-on loads the factory value and a valid write sets it, reset does not
  always @(posedge SYS_CLK) begin
    if (!POR_N) begin
      lfreq_q <= `LFREQ_FACTORY; // [RULE_09]
    end else if (wr_lfreq && lf_ok && w_strb_q[1:0] == 2'b11) begin
      lfreq_q <= lf_new; // [RULE_09]
    end
  end

  // strap captured while reset is held
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      irq_sel_q <= irq_sel_s1_q; // [RULE_03]
    end
  end

  // control registers and command queue
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      ctrl_q <= 4'h0;
      nplc_q <= `NPLC_RESET;
      err_q <= 1'b0;
      pend_q <= 8'h00;
      exec_q <= 16'h0000;
    end else begin
      if (wr_ctrl && w_strb_q[0]) begin
        ctrl_q <= {w_data_q[3], 1'b0, w_data_q[1:0]};
      end
      if (wr_nplc && w_strb_q[0] && w_data_q[7:0] != 8'h00) begin
        nplc_q <= w_data_q[7:0];
      end
      if (wr_lfreq && !lf_ok) begin
        err_q <= 1'b1;
      end else if (wr_stat && w_strb_q[0] && w_data_q[`STAT_ERR_BIT]) begin
        err_q <= 1'b0;
      end
      if (host_clear) begin
        pend_q <= 8'h00; // [RULE_17]
      end else if (meas_start) begin
        exec_q <= exec_q + {8'h00, pend_q} + {15'h0000, wr_cmd}; // [RULE_17]
        pend_q <= 8'h00;
      end else if (wr_cmd) begin
        if (state_q == ST_WAIT) begin
          pend_q <= (pend_q == 8'hff) ? pend_q : pend_q + 8'h01; // [RULE_17]
        end else begin
          exec_q <= exec_q + 16'h0001;
        end
      end
    end
  end

  // trigger-measure-complete sequencer
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
      cyc_q <= 20'h00000;
      lc_q <= 8'h00;
      pulse_q <= 8'h00;
      count_q <= 16'h0000;
      MEAS_COMPLETE <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          MEAS_COMPLETE <= 1'b0;
          if (hs_enable) begin
            state_q <= ST_WAIT; // [RULE_16] [RULE_15]
          end
        end
        ST_WAIT: begin
          if (!hs_enable || host_clear) begin
            state_q <= ST_IDLE;
          end else if (meas_start) begin
            state_q <= ST_MEAS; // [RULE_12]
            cyc_q <= 20'h00000;
            lc_q <= nplc_q;
          end
        end
        ST_MEAS: begin
          if (host_clear) begin
            state_q <= ST_IDLE;
          end else if (meas_end) begin
            state_q <= ST_DONE; // [RULE_06]
            MEAS_COMPLETE <= 1'b1; // [RULE_13]
            pulse_q <= COMPLETE_CYCLES;
            count_q <= count_q + 16'h0001;
          end else if (cyc_q == lc_len - 20'd1) begin
            cyc_q <= 20'h00000;
            lc_q <= lc_q - 8'h01; // [RULE_06]
          end else begin
            cyc_q <= cyc_q + 20'h00001;
          end
        end
        ST_DONE: begin
          if (pulse_q == 8'h01) begin
            MEAS_COMPLETE <= 1'b0; // [RULE_18]
            state_q <= ST_IDLE; // [RULE_14]
          end
          pulse_q <= pulse_q - 8'h01;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // interrupt request and acknowledge daisy chain
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      irq_pend_q <= 1'b0;
      ack_hold_q <= 1'b0;
      IRQ_O <= 7'h00;
      IRQ_OE <= 7'h00;
      IACKOUT_N <= 1'b1;
    end else begin
      // an acknowledge we answered stays blocked until it is withdrawn
      if (iack_s2_q) begin
        ack_hold_q <= 1'b0;
      end else if (irq_pend_q) begin
        ack_hold_q <= 1'b1; // [RULE_05]
      end
      IRQ_O <= 7'h00;
      if (meas_end && ctrl_q[`CTRL_IRQ_EN] && irq_sel_q != 3'h0) begin
        irq_pend_q <= 1'b1; // [RULE_02]
      end else if (!iack_s2_q && irq_pend_q) begin
        irq_pend_q <= 1'b0; // [RULE_02] [RULE_05]
      end else if (host_clear) begin
        irq_pend_q <= 1'b0;
      end
      IRQ_OE <= (irq_pend_q && irq_sel_q != 3'h0) ?
        (7'h01 << (irq_sel_q - 3'h1)) : 7'h00; // [RULE_03] [RULE_04]
      IACKOUT_N <= iack_s2_q | irq_pend_q | ack_hold_q; // [RULE_05]
    end
  end

  // axi4-lite write channel
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_v_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_v_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_v_q <= 1'b0;
        w_v_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= !wr_map ? `RESP_DECERR :
          (wr_lfreq && !lf_ok) ? `RESP_SLVERR : `RESP_OKAY; // [RULE_07]
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // read mux
  always @* begin
    rdata_d = 32'h00000000;
    rresp_d = `RESP_OKAY;
    case ({S_AXI_ARADDR[7:2], 2'b00})
      `ADDR_CTRL: rdata_d = {28'h0000000, ctrl_q};
      `ADDR_LFREQ: rdata_d = {8'h00, `LFREQ_MAX, `LFREQ_MIN, lfreq_q}; // [RULE_10]
      `ADDR_NPLC: rdata_d = {24'h000000, nplc_q};
      `ADDR_STATUS: rdata_d = {exec_q, pend_q, 1'b0, irq_sel_q,
        err_q, irq_pend_q, state_q};
      `ADDR_CMD: rdata_d = 32'h00000000;
      `ADDR_COUNT: rdata_d = {16'h0000, count_q};
      default: rresp_d = `RESP_DECERR;
    endcase
  end

  // axi4-lite read channel
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rdata_d;
      S_AXI_RRESP <= rresp_d;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end
endmodule

// >>> sim/mux_model.sv
// solid-state multiplexer model on the digital bus
module mux_model #(parameter [7:0] CHANNELS = 8'd3) ( // channels scanned before done is raised
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic complete,
  output logic trig,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b0;
  logic [7:0] chan = 8'h00;
  logic [7:0] wait_q = 8'h00;
  initial trig = 1'b0;
  initial done = 1'b1;
  always @(posedge clk) begin
    prev <= complete;
    if (go) begin
      chan <= 8'h00;
      done <= 1'b0;
      trig <= 1'b0;
      wait_q <= slow ? 8'd40 : 8'd2;
    end else if (complete && !prev) begin
      trig <= 1'b0;
      chan <= chan + 8'h01;
      done <= chan + 8'h01 == CHANNELS;
    end else if (!complete && prev && !done) begin
      wait_q <= slow ? 8'd40 : 8'd2;
    end else if (wait_q != 8'h00) begin
      wait_q <= wait_q - 8'h01;
      trig <= wait_q == 8'h01;
    end
  end
endmodule

// >>> sim/scan_meter_chk.sv
// port assertions for the scanning meter handshake
module scan_meter_chk #(parameter [7:0] COMPLETE_CYCLES = 8'd50) (
  // clock and reset
  input wire SYS_CLK,
  input wire RESET_N,
  // digital bus
  input wire TRIG_IN,
  input wire MEAS_COMPLETE,
  // backplane interrupt
  input wire [2:0] IRQ_SEL,
  input wire [6:0] IRQ_O,
  input wire [6:0] IRQ_OE,
  input wire IACKIN_N,
  input wire IACKOUT_N
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] hi_q;
  reg seen_q;
  reg held_q;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // pulse length and trigger seen since the last complete
  always @(posedge SYS_CLK) begin
    hi_q <= (!RESET_N || !MEAS_COMPLETE) ? 8'h00 : hi_q + 8'h01;
    seen_q <= RESET_N && ($rose(TRIG_IN) || (seen_q && !MEAS_COMPLETE));
    held_q <= RESET_N && !IACKIN_N && (held_q || |IRQ_OE);
  end
  sequence s_ack_quiet;
    (IRQ_OE == 7'h00 && $stable(IACKIN_N)) [*5];
  endsequence
  property p_irq_low; IRQ_O == 7'h00; endproperty
  property p_irq_line; |IRQ_OE |-> IRQ_OE == 7'h01 << (IRQ_SEL - 3'h1); endproperty
  property p_irq_off; IRQ_SEL == 3'h0 |-> IRQ_OE == 7'h00; endproperty
  property p_ack_pass; s_ack_quiet ##0 !held_q |-> IACKOUT_N == IACKIN_N; endproperty
  property p_ack_hold; held_q |-> IACKOUT_N; endproperty
  property p_ack_block; |IRQ_OE && |$past(IRQ_OE) |-> IACKOUT_N; endproperty
  property p_done_width; $fell(MEAS_COMPLETE) |-> hi_q == COMPLETE_CYCLES; endproperty
  property p_done_gap; $fell(MEAS_COMPLETE) |-> !MEAS_COMPLETE [*2]; endproperty
  property p_needs_trig; $rose(MEAS_COMPLETE) |-> seen_q; endproperty
  property p_trig_lat; $rose(TRIG_IN) && !MEAS_COMPLETE |=> !MEAS_COMPLETE [*3]; endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq level high");
  a_irq_line: assert property (p_irq_line) else $error("irq line wrong");
  a_irq_off: assert property (p_irq_off) else $error("irq while off");
  a_ack_pass: assert property (p_ack_pass) else $error("ack not passed");
  a_ack_block: assert property (p_ack_block) else $error("ack leaked");
  a_ack_hold: assert property (p_ack_hold) else $error("taken ack passed on");
  a_done_width: assert property (p_done_width) else $error("pulse width");
  a_done_gap: assert property (p_done_gap) else $error("no idle gap");
  a_needs_trig: assert property (p_needs_trig) else $error("untriggered");
  a_trig_lat: assert property (p_trig_lat) else $error("early complete");
endmodule
bind scanning_meter_handshake scan_meter_chk #(.COMPLETE_CYCLES(COMPLETE_CYCLES)) i_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .TRIG_IN(TRIG_IN), .MEAS_COMPLETE(MEAS_COMPLETE),
  .IRQ_SEL(IRQ_SEL), .IRQ_O(IRQ_O), .IRQ_OE(IRQ_OE), .IACKIN_N(IACKIN_N),
  .IACKOUT_N(IACKOUT_N));

// >>> sim/scanning_meter_handshake_tb_top.sv
// bench for the scanning meter handshake
module scanning_meter_handshake_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk = 0, rn = 0, pn = 0, ackin = 1, go = 0, slow = 0;
  reg awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  reg [7:0] awa = 0, ara = 0;
  reg [31:0] wd = 0, rd, base;
  reg [2:0] sel = 3'h1;
  reg [1:0] rs;
  wire awr, wrdy, bv, arr, rv, trig, mc, ackout, done;
  wire [1:0] bresp, rresp;
  wire [31:0] rdt;
  wire [6:0] irqo, oe;
  integer fail_count = 0, n_compared = 0, cyc = 0;
  scanning_meter_handshake #(.LC50_CYCLES(20'd10), .LC60_CYCLES(20'd8)) i_scanning_meter_handshake (
    .SYS_CLK(clk), .RESET_N(rn), .POR_N(pn), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .TRIG_IN(trig),
    .MEAS_COMPLETE(mc), .IRQ_SEL(sel), .IRQ_O(irqo), .IRQ_OE(oe), .IACKIN_N(ackin),
    .IACKOUT_N(ackout));
  mux_model i_mux_model (.clk(clk), .go(go), .slow(slow), .complete(mc), .trig(trig),
    .done(done));
  initial forever #10 clk = ~clk;
  task test_done;
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end
  task cmp(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task axw(input [7:0] a, input [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    br <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
    rs = bresp;
    br <= 0;
  endtask
  task axr(input [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    rd = rdt;
    rs = rresp;
    rr <= 0;
  endtask
  task rst(input [2:0] s, input p);
    @(posedge clk);
    rn <= 0;
    pn <= p;
    sel <= s;
    repeat (20) @(posedge clk);
    rn <= 1;
    pn <= 1;
  endtask
  task start;
    go <= 1;
    @(posedge clk);
    go <= 0;
    @(posedge clk);
  endtask
  task t_freq;
    axr(8'h04);
    cmp(rd, 32'h003c323c);
    axw(8'h04, 32'd55);
    cmp(rs, 2'b10);
    axr(8'h0c);
    cmp(rd[3], 1'b1);
    axr(8'h04);
    cmp(rd[7:0], 8'd60);
    axw(8'h04, 32'h100);
    axr(8'h04);
    cmp(rd[7:0], 8'd50);
    axw(8'h04, 32'h200);
    axr(8'h04);
    cmp(rd[7:0], 8'd60);
    axw(8'h04, 32'd50);
    rst(3'h1, 1'b1);
    axr(8'h04);
    cmp(rd[7:0], 8'd50);
    axr(8'h40);
    cmp(rs, 2'b11);
  endtask
  task t_scan(input s, input [2:0] l);
    rst(l, 1'b1);
    slow <= s;
    axw(8'h00, 32'h0b);
    axr(8'h14);
    base = rd;
    start;
    while (!done) @(posedge clk);
    repeat (60) @(posedge clk);
    axr(8'h14);
    cmp(rd, base + 32'd3);
    cmp(oe, l == 3'h0 ? 7'h00 : 7'h01 << (l - 3'h1));
    ackin <= 0;
    repeat (8) @(posedge clk);
    cmp(oe, 7'h00);
    cmp(ackout, l != 3'h0);
    ackin <= 1;
  endtask
  task t_relay;
    axw(8'h00, 32'h01);
    axr(8'h14);
    base = rd;
    start;
    repeat (100) @(posedge clk);
    axr(8'h14);
    cmp(rd, base);
  endtask
  task t_queue;
    axw(8'h00, 32'h03);
    axw(8'h10, 32'h01);
    axw(8'h10, 32'h02);
    axr(8'h0c);
    cmp(rd[15:8], 8'd2);
    axw(8'h00, 32'h07);
    axr(8'h0c);
    cmp(rd[15:8], 8'd0);
    axw(8'h10, 32'h01);
    start;
    repeat (20) @(posedge clk);
    axr(8'h0c);
    cmp(rd[31:8], 24'h000100);
  endtask
  initial begin
    rst(3'h1, 1'b0);
    t_freq;
    t_scan(1'b0, 3'h1);
    t_scan(1'b1, 3'h3);
    t_scan(1'b0, 3'h0);
    t_relay;
    t_queue;
    test_done;
  end
endmodule
